// ==== design/fes_host.sv ====
// Purpose: host-side sequencer that writes commands and polls status
// Assumes: flash pins sampled synchronously; one access at a time
// Notes: wait ops poll toggle bits until two stable reads or timeout
`timescale 1ns/1ps
module fes_host #(
    parameter int DataWidth = 16,
    parameter int AddrWidth = 22,
    parameter longint SectorEraseCycles = fes_pkg::SectorEraseCyc,
    parameter longint ChipEraseCycles = fes_pkg::ChipEraseCyc,
    parameter longint ProgramCycles = fes_pkg::ProgramCyc,
    parameter longint EraseSuspCycles = fes_pkg::EraseSuspCyc,
    parameter longint ProgSuspCycles = fes_pkg::ProgSuspCyc,
    parameter longint ResumeGapCycles = fes_pkg::ResumeGapCyc,
    parameter longint EvalCycles = fes_pkg::EvalCyc
) (
    input wire logic clk,
    input wire logic resetn,
    // user request side
    input wire logic reqValid,
    output logic reqReady,
    input wire fes_pkg::fes_op_t reqOp,
    input wire logic [AddrWidth-1:0] reqAddr,
    input wire logic [DataWidth-1:0] reqData,
    input wire logic resumeSeen,
    output logic rspValid,
    output logic [DataWidth-1:0] rspData,
    output logic rspTimeout,
    output logic rspExceeded,
    output logic suspendGapOk,
    // flash pins
    output logic [AddrWidth-1:0] flashAddr,
    output logic chipEnableN,
    output logic outEnableN,
    output logic writeEnableN,
    input wire logic [DataWidth-1:0] flashDataIn,
    output logic [DataWidth-1:0] flashDataOut,
    output logic flashDataOe,
    input wire logic readyBusyN
);
    // ==========================================================
    // state
    typedef enum logic [2:0] {
        FES_IDLE, FES_WLOW, FES_WHIGH, FES_RLOW, FES_RHIGH, FES_DONE
    } fes_state_t;

    typedef struct packed {
        fes_state_t st;           // sequencer state
        fes_pkg::fes_op_t op;     // op in progress
        logic [AddrWidth-1:0] addr;
        logic [DataWidth-1:0] wdata;
        logic [DataWidth-1:0] last; // previous status read
        logic haveLast;           // a status read already taken
        logic [7:0] phase;        // strobe phase counter
        logic [47:0] budget;      // remaining wait cycles
        logic [47:0] gap;         // cycles since last resume
        logic [DataWidth-1:0] rdata;
        logic timeout;
        logic exceeded;
        logic rsp;
        logic ce;
        logic oe;
        logic we;
        logic doe;
    } fes_s_t;

    fes_s_t s_reg, s_next;

    // polling ops keep strobing reads; others end after one access
    function automatic logic isWait(input fes_pkg::fes_op_t o);
        return !(o == fes_pkg::FES_OP_WRITE || o == fes_pkg::FES_OP_READ);
    endfunction

    // timeout budget per wait kind
    function automatic logic [47:0] budgetFor(input fes_pkg::fes_op_t o);
        case (o)
            fes_pkg::FES_OP_WAIT_PROG: return 48'(ProgramCycles);
            fes_pkg::FES_OP_WAIT_SECTOR:
                return 48'(SectorEraseCycles);
            fes_pkg::FES_OP_WAIT_CHIP: return 48'(ChipEraseCycles);
            fes_pkg::FES_OP_WAIT_ESUSP: return 48'(EraseSuspCycles);
            fes_pkg::FES_OP_WAIT_PSUSP: return 48'(ProgSuspCycles);
            fes_pkg::FES_OP_WAIT_EVAL: return 48'(EvalCycles);
            default: return 48'h0;
        endcase
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic [DataWidth-1:0] diff;
        diff = '0;
        s_next = s_reg;
        s_next.rsp = 1'b0;
        if (s_reg.budget != 48'h0) begin
            s_next.budget = s_reg.budget - 48'h1;
        end
        // resume-to-suspend spacing; host caller checks suspendGapOk
        if (resumeSeen) begin
            s_next.gap = 48'h0;
        end else if (s_reg.gap < 48'(ResumeGapCycles)) begin
            s_next.gap = s_reg.gap + 48'h1;
        end
        case (s_reg.st)
            FES_IDLE: begin
                if (reqValid) begin
                    s_next.op = reqOp;
                    s_next.addr = reqAddr;
                    s_next.wdata = reqData;
                    s_next.haveLast = 1'b0;
                    s_next.timeout = 1'b0;
                    s_next.exceeded = 1'b0;
                    s_next.phase = 8'h0;
                    s_next.budget = budgetFor(reqOp);
                    // write cycle: we and ce go low in the same cycle, ce rises first
                    if (reqOp == fes_pkg::FES_OP_WRITE) begin
                        s_next.we = 1'b1;
                        s_next.doe = 1'b1;
                        s_next.ce = 1'b1;
                        s_next.st = FES_WLOW;
                    end else begin
                        s_next.ce = 1'b1;
                        s_next.oe = 1'b1;
                        s_next.st = FES_RLOW;
                    end
                end
            end
            FES_WLOW: begin
                s_next.phase = s_reg.phase + 8'h1;
                if (s_reg.phase == 8'(fes_pkg::StrobeLowCyc - 1)) begin
                    // rising ce latches data; we released after
                    s_next.ce = 1'b0;
                    s_next.phase = 8'h0;
                    s_next.st = FES_WHIGH;
                end
            end
            FES_WHIGH: begin
                s_next.phase = s_reg.phase + 8'h1;
                s_next.we = 1'b0;
                if (s_reg.phase == 8'(fes_pkg::StrobeHighCyc - 1)) begin
                    s_next.doe = 1'b0;
                    s_next.st = FES_DONE;
                end
            end
            FES_RLOW: begin
                s_next.phase = s_reg.phase + 8'h1;
                if (s_reg.phase == 8'(fes_pkg::AccessCyc - 1)) begin
                    s_next.rdata = flashDataIn;
                    s_next.last = flashDataIn;
                    s_next.haveLast = 1'b1;
                    diff = flashDataIn ^ s_reg.last;
                    // both ce and oe pulse so either delimiter works
                    s_next.ce = 1'b0;
                    s_next.oe = 1'b0;
                    s_next.phase = 8'h0;
                    if (flashDataIn[fes_pkg::ExceedBitPos]) begin
                        s_next.exceeded = 1'b1;
                    end
                    // stable toggle bits on two reads means done; the
                    // polling bit is then true data
                    if (!isWait(s_reg.op)) begin
                        s_next.st = FES_DONE;
                    end else if (s_reg.haveLast &&
                        !diff[fes_pkg::ToggleBitPos] &&
                        !diff[fes_pkg::SuspToggleBitPos]) begin
                        s_next.st = FES_DONE;
                    end else if (s_reg.budget == 48'h0) begin
                        s_next.timeout = 1'b1;
                        s_next.st = FES_DONE;
                    end else begin
                        s_next.st = FES_RHIGH;
                    end
                end
            end
            FES_RHIGH: begin
                s_next.phase = s_reg.phase + 8'h1;
                if (s_reg.phase == 8'(fes_pkg::StrobeHighCyc - 1)) begin
                    s_next.ce = 1'b1;
                    s_next.oe = 1'b1;
                    s_next.phase = 8'h0;
                    s_next.st = FES_RLOW;
                end
            end
            FES_DONE: begin
                s_next.rsp = 1'b1;
                s_next.st = FES_IDLE;
            end
            default: s_next.st = FES_IDLE;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.st <= FES_IDLE;
            s_reg.gap <= 48'(ResumeGapCycles);
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // outputs; readyBusyN used only to gate suspendGapOk
    assign reqReady = (s_reg.st == FES_IDLE);
    assign rspValid = s_reg.rsp;
    assign rspData = s_reg.rdata;
    assign rspTimeout = s_reg.timeout;
    assign rspExceeded = s_reg.exceeded;
    assign suspendGapOk = (s_reg.gap >= 48'(ResumeGapCycles)) && readyBusyN;
    assign flashAddr = s_reg.addr;
    assign chipEnableN = ~s_reg.ce;
    assign outEnableN = ~s_reg.oe;
    assign writeEnableN = ~s_reg.we;
    assign flashDataOut = s_reg.wdata;
    assign flashDataOe = s_reg.doe;
endmodule

// ==== design/fes_pkg.sv ====
// Purpose: constants for the flash embedded-operation host sequencer
// Assumes: 200 MHz system clock
// Notes: times kept in their printed unit, cycle counts derived here
package fes_pkg;
    // ==========================================================
    // clock
    localparam int ClkPeriodPs = 5000;
    // ==========================================================
    // device times
    localparam longint SectorEraseMaxMs = 1000;
    localparam longint ChipEraseMaxMs = 65400;
    localparam longint ProgramMaxUs = 1200;
    localparam longint EraseSuspendLatNs = 30000;
    localparam longint ProgramSuspendLatNs = 23500;
    localparam longint ResumeToSuspendNs = 100000;
    localparam longint EvalStatusMaxUs = 30;
    localparam longint StrobeLowNs = 25;
    localparam longint StrobeHighNs = 20;
    localparam longint AccessNs = 70;
    // ==========================================================
    // derived cycle counts (least times round up, longest round down)
    localparam longint SectorEraseCyc = SectorEraseMaxMs * 200000;
    localparam longint ChipEraseCyc = ChipEraseMaxMs * 200000;
    localparam longint ProgramCyc = ProgramMaxUs * 200;
    localparam longint EraseSuspCyc = EraseSuspendLatNs * 1000 / ClkPeriodPs;
    localparam longint ProgSuspCyc = ProgramSuspendLatNs * 1000 / ClkPeriodPs;
    localparam longint ResumeGapCyc = (ResumeToSuspendNs * 1000 +
        ClkPeriodPs - 1) / ClkPeriodPs;
    localparam longint EvalCyc = EvalStatusMaxUs * 200;
    localparam int StrobeLowCyc = int'((StrobeLowNs * 1000 + ClkPeriodPs - 1)
        / ClkPeriodPs);
    localparam int StrobeHighCyc = int'((StrobeHighNs * 1000 + ClkPeriodPs
        - 1) / ClkPeriodPs);
    localparam int AccessCyc = int'((AccessNs * 1000 + ClkPeriodPs - 1)
        / ClkPeriodPs);
    // ==========================================================
    // status bit positions in the data word
    localparam int PollBitPos = 7;
    localparam int ToggleBitPos = 6;
    localparam int ExceedBitPos = 5;
    localparam int SuspToggleBitPos = 2;
    // ==========================================================
    // operation kinds requested by the user side
    typedef enum logic [2:0] {
        FES_OP_WRITE,
        FES_OP_READ,
        FES_OP_WAIT_PROG,
        FES_OP_WAIT_SECTOR,
        FES_OP_WAIT_CHIP,
        FES_OP_WAIT_ESUSP,
        FES_OP_WAIT_PSUSP,
        FES_OP_WAIT_EVAL
    } fes_op_t;
endpackage

// ==== testbench/fes_flash_model.sv ====
// Purpose: behavioural flash device facing the host sequencer
// Assumes: pins sampled on the bench clock, one stored word
// Notes: busy length and exceeded flag are set by the bench
`timescale 1ns/1ps
module fes_flash_model (
    input wire logic clk,
    input wire logic [21:0] addr,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [15:0] dIn,
    input wire logic [15:0] busyLen,
    input wire logic exceedOn,
    output logic [15:0] dOut,
    output logic readyBusyN
);
    // ==========================================================
    // state
    logic [15:0] mem = 16'h0000; // stored array word
    logic [15:0] lastOut = 16'h0000; // last word driven out
    logic [6:0] sec = 7'h00; // sector of the running operation
    logic tog = 1'b0; // toggle phase
    logic ceD = 1'b1;
    logic rdD = 1'b0;
    int busy = 0;
    int acc = 0; // cycles into a read, data is late on purpose
    wire logic rd = !ceN && !oeN;
    // inverted poll bit, toggles, bit2 only in own sector
    wire logic [15:0] stat = {8'h00,
        ~mem[7], tog, exceedOn, 2'b00,
        (addr[21:15] == sec) ? tog : 1'b0, 2'b00};
    // released bus shows the inverse of its last word, never a hold
    assign dOut = (rd && acc >= 12) ? ((busy > 0) ? stat : mem) : ~lastOut;
    assign readyBusyN = (busy == 0);
    // pin watcher: write on chip-enable rise, toggle on read end
    always @(posedge clk) begin
        ceD <= ceN;
        rdD <= rd;
        acc <= rd ? acc + 1 : 0;
        if (rd && acc >= 12)
            lastOut <= dOut;
        if (ceN && !ceD && !weN) begin
            mem <= dIn;
            sec <= addr[21:15];
            busy <= int'(busyLen);
        end else if (busy > 0)
            busy <= busy - 1;
        if (rdD && !rd && busy > 0)
            tog <= ~tog;
    end
endmodule

// ==== testbench/fes_host_asserts.sv ====
// Purpose: pin-level checks on the host sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every sequencer instance
`timescale 1ns/1ps
module fes_host_asserts #(
    parameter longint ResumeGapCycles = 40
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reqReady,
    input wire logic resumeSeen,
    input wire logic suspendGapOk,
    input wire logic chipEnableN,
    input wire logic outEnableN,
    input wire logic writeEnableN,
    input wire logic flashDataOe,
    input wire logic readyBusyN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    longint gapCnt; // cycles since resume, saturates past the gap
    // own count of the resume gap; it runs one past the design's
    // saturation, so reaching the gap compares exactly
    always_ff @(posedge clk) begin
        if (!resetn || (!resumeSeen && gapCnt <= ResumeGapCycles))
            gapCnt <= resetn ? gapCnt + 64'h1 : ResumeGapCycles + 64'h1;
        else if (resumeSeen)
            gapCnt <= 64'h0;
    end
    // ==========================================================
    // properties
    // we must still be low at the edge where the ce rise is seen;
    // driven data marks a write, since reads raise ce too
    property p_we_hold;
        $rose(chipEnableN) && flashDataOe |-> !writeEnableN;
    endproperty
    a_we_hold: assert property (p_we_hold)
        else $error("we rose early");
    property p_drv;
        !writeEnableN |-> flashDataOe;
    endproperty
    a_drv: assert property (p_drv)
        else $error("data not driven");
    property p_ce_w;
        $fell(chipEnableN) && !writeEnableN |-> !chipEnableN[*5];
    endproperty
    a_ce_w: assert property (p_ce_w)
        else $error("ce pulse short");
    property p_clash;
        outEnableN || writeEnableN;
    endproperty
    a_clash: assert property (p_clash)
        else $error("oe and we low");
    property p_rd_len;
        $fell(outEnableN) |-> !outEnableN[*8] ##1 !outEnableN[*6];
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read short");
    property p_rd_ce;
        !outEnableN |-> !chipEnableN && !reqReady;
    endproperty
    a_rd_ce: assert property (p_rd_ce)
        else $error("read unframed");
    property p_gap_ok;
        suspendGapOk |-> readyBusyN && gapCnt >= ResumeGapCycles;
    endproperty
    a_gap_ok: assert property (p_gap_ok)
        else $error("gap too soon");
    property p_gap_due;
        readyBusyN && gapCnt >= ResumeGapCycles |-> suspendGapOk;
    endproperty
    a_gap_due: assert property (p_gap_due)
        else $error("gap not flagged");
endmodule
bind fes_host fes_host_asserts #(.ResumeGapCycles(ResumeGapCycles)) chk (
    .clk(clk), .resetn(resetn), .reqReady(reqReady),
    .resumeSeen(resumeSeen), .suspendGapOk(suspendGapOk),
    .chipEnableN(chipEnableN), .outEnableN(outEnableN),
    .writeEnableN(writeEnableN), .flashDataOe(flashDataOe),
    .readyBusyN(readyBusyN));

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the host sequencer
// Assumes: short budgets so each wait ends in a few hundred cycles
// Notes: expected words come from a queue of what was written
`timescale 1ns/1ps
module tb;
    localparam longint Bud = 300; // polling budget of every wait kind
    localparam int Gap = 40; // shortened resume-to-suspend spacing
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic reqValid = 1'b0;
    fes_pkg::fes_op_t reqOp = fes_pkg::FES_OP_READ;
    logic [21:0] reqAddr = 22'h000000;
    logic [15:0] reqData = 16'h0000;
    logic resumeSeen = 1'b0;
    logic [15:0] busyLen = 16'h0014;
    logic exceedOn = 1'b0;
    logic reqReady, rspValid, rspTimeout, rspExceeded, suspendGapOk;
    logic chipEnableN, outEnableN, writeEnableN, flashDataOe, readyBusyN;
    logic [21:0] flashAddr;
    logic [15:0] rspData, flashDataOut, devOut, dataBus, gotData;
    logic gotTo, gotEx;
    int n_fail = 0;
    int comparisons = 0;
    int seed = 56227;
    int wrQ[$]; // words written, oldest first
    assign dataBus = flashDataOe ? flashDataOut : devOut;
    always #2.5 clk = ~clk;
    fes_host #(.SectorEraseCycles(Bud), .ChipEraseCycles(Bud),
        .ProgramCycles(Bud), .EraseSuspCycles(Bud), .ProgSuspCycles(Bud),
        .ResumeGapCycles(Gap), .EvalCycles(Bud)) dut (.clk(clk),
        .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData),
        .resumeSeen(resumeSeen), .rspValid(rspValid), .rspData(rspData),
        .rspTimeout(rspTimeout), .rspExceeded(rspExceeded),
        .suspendGapOk(suspendGapOk), .flashAddr(flashAddr),
        .chipEnableN(chipEnableN), .outEnableN(outEnableN),
        .writeEnableN(writeEnableN), .flashDataIn(dataBus),
        .flashDataOut(flashDataOut), .flashDataOe(flashDataOe),
        .readyBusyN(readyBusyN));
    fes_flash_model flash (.clk(clk), .addr(flashAddr), .ceN(chipEnableN),
        .oeN(outEnableN), .weN(writeEnableN), .dIn(dataBus),
        .busyLen(busyLen), .exceedOn(exceedOn), .dOut(devOut),
        .readyBusyN(readyBusyN));
    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk_data(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(logic got, logic exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request held until taken, then its answer is captured
    task automatic do_op(fes_pkg::fes_op_t op, logic [21:0] a,
        logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        reqOp <= op;
        reqAddr <= a;
        reqData <= d;
        reqValid <= 1'b1;
        #1;
        while (reqReady !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        while (rspValid !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        // an answer that never came is a mismatch of its own
        if (n >= 20000)
            n_fail++;
        gotData = rspData;
        gotTo = rspTimeout;
        gotEx = rspExceeded;
    endtask
    // watchdog well past the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    // main sequence: every wait kind, a timeout, then the resume gap
    initial begin
        logic [15:0] d;
        logic [21:0] a;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 2; k < 8; k++) begin
            d = 16'($random(seed)) & 16'hffdf; // bit5 clear in the array
            a = 22'($random(seed));
            // long enough that the first poll always sees status
            busyLen <= 16'(40 + {$random(seed)} % 80);
            exceedOn <= (k == 7);
            do_op(fes_pkg::FES_OP_WRITE, a, d);
            wrQ.push_back(int'(d));
            do_op(fes_pkg::fes_op_t'(k), a, 16'h0000);
            chk_data(gotData, 16'(wrQ.pop_front()));
            chk_flag(gotTo, 1'b0);
            chk_flag(gotEx, k == 7);
        end
        exceedOn <= 1'b0;
        busyLen <= 16'h03e8; // far beyond the budget
        do_op(fes_pkg::FES_OP_WRITE, a, ~d);
        // a plain read while busy shows the complement of bit 7
        do_op(fes_pkg::FES_OP_READ, a, 16'h0000);
        chk_flag(gotData[7], d[7]);
        do_op(fes_pkg::FES_OP_WAIT_SECTOR, a, 16'h0000);
        chk_flag(gotTo, 1'b1);
        while (readyBusyN !== 1'b1) @(posedge clk);
        do_op(fes_pkg::FES_OP_READ, a, 16'h0000);
        chk_data(gotData, ~d);
        // resume pulse taken at the next edge; flag rises Gap edges on
        @(posedge clk);
        resumeSeen <= 1'b1;
        @(posedge clk);
        resumeSeen <= 1'b0;
        repeat (Gap - 1) @(posedge clk);
        #1;
        chk_flag(suspendGapOk, 1'b0);
        @(posedge clk);
        #1;
        chk_flag(suspendGapOk, 1'b1);
        report_and_stop();
    end
endmodule
